// ===== hdl/gp_timer_map.vh
`ifndef GP_TIMER_MAP_VH
`define GP_TIMER_MAP_VH
`define DIR_UP        2'h0
`define DIR_DOWN      2'h1
`define DIR_CENTER    2'h2
`define CLK_INTERNAL  2'h0
`define CLK_ENCODER   2'h1
`define CLK_TRIGGER   2'h2
`define CH_CAPTURE    2'h0
`define CH_COMPARE    2'h1
`define CH_PWM        2'h2
`define CH_ONEPULSE   2'h3
`define CNT_RESET     16'h0000
`define RELOAD_RESET  16'hFFFF
`define PRESC_RESET   16'h0000
`endif

// ===== hdl/timer_channel.v
`timescale 1ns/1ps
`include "gp_timer_map.vh"
module timer_channel #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [1:0]       mode,
	input  wire [WIDTH-1:0] compare,
	input  wire [WIDTH-1:0] count,
	input  wire             tick,
	input  wire             update,
	input  wire             cap_edge,
	output reg  [WIDTH-1:0] captured_q,
	output reg              out_q,
	output reg              event_q
);
	reg fired_q;
	always @(posedge clk) begin
		if (rst) begin
			captured_q <= {WIDTH{1'b0}};
			out_q      <= 1'b0;
			event_q    <= 1'b0;
			fired_q    <= 1'b0;
		end else begin
			event_q <= 1'b0;
			case (mode)
			`CH_CAPTURE: begin
				out_q <= 1'b0;
				if (cap_edge) begin
					captured_q <= count;
					event_q    <= 1'b1;
				end
			end
			`CH_COMPARE: begin
				if (tick && count == compare) begin
					out_q   <= ~out_q;
					event_q <= 1'b1;
				end
			end
			`CH_PWM: begin
				out_q <= (count < compare);
				if (tick && count == compare)
					event_q <= 1'b1;
			end
			default: begin
				// One pulse: high from the match until the next update.
				if (update) begin
					out_q   <= 1'b0;
					fired_q <= 1'b0;
				end else if (tick && count == compare && !fired_q) begin
					out_q   <= 1'b1;
					fired_q <= 1'b1;
					event_q <= 1'b1;
				end
			end
			endcase
		end
	end
endmodule // timer_channel

// ===== hdl/gp_timer.v
`timescale 1ns/1ps
`include "gp_timer_map.vh"
module gp_timer #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             enable,
	input  wire [1:0]       dir_mode,
	input  wire [1:0]       clk_mode,
	input  wire             down,
	input  wire [WIDTH-1:0] prescale,
	input  wire [WIDTH-1:0] reload,
	input  wire             dbg_freeze_en,
	input  wire             dbg_halt,
	input  wire             trig_reset_en,
	input  wire             trig_in,
	input  wire [7:0]       ch_mode,
	input  wire [4*WIDTH-1:0] ch_compare,
	input  wire [3:0]       ch_in,
	input  wire             enc_a,
	input  wire             enc_b,
	input  wire [2:0]       hall_in,
	input  wire             dma_en,
	input  wire             dma_ack,
	output reg  [WIDTH-1:0] count_q,
	output reg              dir_down_q,
	output reg              update_q,
	output wire             trig_out,
	output wire [4*WIDTH-1:0] ch_captured,
	output wire [3:0]       ch_out,
	output wire [3:0]       ch_event,
	output reg              hall_change_q,
	output reg              dma_req_q
);
	// Three-stage synchronisers for all pin inputs.
	reg [9:0] s1_q;
	reg [9:0] s2_q;
	reg [9:0] s3_q;
	wire [9:0] pins = {trig_in, hall_in, enc_b, enc_a, ch_in};
	always @(posedge clk) begin
		if (rst) begin
			s1_q <= 10'h000;
			s2_q <= 10'h000;
			s3_q <= 10'h000;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// A change counts once stages two and three agree.
	reg  [9:0] stable_q;
	reg  [9:0] prev_q;
	wire [9:0] agree = ~(s2_q ^ s3_q);
	always @(posedge clk) begin
		if (rst) begin
			stable_q <= 10'h000;
			prev_q   <= 10'h000;
		end else begin
			stable_q <= (agree & s3_q) | (~agree & stable_q);
			prev_q   <= stable_q;
		end
	end
	wire [3:0] cap_edge = stable_q[3:0] & ~prev_q[3:0];
	wire       a_now    = stable_q[4];
	wire       b_now    = stable_q[5];
	wire       a_prev   = prev_q[4];
	wire       b_prev   = prev_q[5];
	wire       trig_rise = stable_q[9] & ~prev_q[9];
	wire       hall_chg  = |(stable_q[8:6] ^ prev_q[8:6]);

	// Quadrature: any edge steps once; direction from phase order.
	wire enc_step = (a_now ^ a_prev) | (b_now ^ b_prev);
	wire enc_down = (a_now ^ a_prev) ? (a_now == b_now) : (a_now != b_now);

	wire frozen = dbg_freeze_en & dbg_halt;
	wire run    = enable & ~frozen;

	// Prescaler; a value N divides by N+1, so 16 bits reach 65536.
	reg  [WIDTH-1:0] psc_q;
	wire             src_tick;
	assign src_tick = (clk_mode == `CLK_TRIGGER) ? trig_rise : 1'b1;
	// Wrap on reaching or passing the limit, so a lowered prescale never
	// strands the divider on a 65536-cycle detour.
	wire psc_wrap = (psc_q >= prescale);
	wire tick = run && (clk_mode == `CLK_ENCODER ? enc_step
		: (src_tick && psc_wrap));
	always @(posedge clk) begin
		if (rst) begin
			psc_q <= `PRESC_RESET;
		end else if (run && src_tick && clk_mode != `CLK_ENCODER) begin
			psc_q <= psc_wrap ? `PRESC_RESET : psc_q + 16'h0001;
		end
	end

	wire going_down = (clk_mode == `CLK_ENCODER) ? enc_down
		: (dir_mode == `DIR_CENTER) ? dir_down_q
		: (dir_mode == `DIR_DOWN) | down;
	wire at_top = (count_q >= reload);
	wire at_bot = (count_q == `CNT_RESET);
	wire sync_rst = trig_reset_en & trig_rise;
	always @(posedge clk) begin
		if (rst) begin
			count_q    <= `CNT_RESET;
			dir_down_q <= 1'b0;
			update_q   <= 1'b0;
		end else begin
			update_q <= 1'b0;
			if (sync_rst) begin
				count_q  <= `CNT_RESET;
				update_q <= 1'b1;
			end else if (tick) begin
				if (dir_mode == `DIR_CENTER && clk_mode != `CLK_ENCODER) begin
					if (!dir_down_q && count_q >= reload - 16'h0001) begin
						count_q    <= reload;
						dir_down_q <= 1'b1;
						update_q   <= 1'b1;
					end else if (dir_down_q && count_q <= 16'h0001) begin
						count_q    <= `CNT_RESET;
						dir_down_q <= 1'b0;
						update_q   <= 1'b1;
					end else begin
						count_q <= dir_down_q ? count_q - 16'h0001
							: count_q + 16'h0001;
					end
				end else if (going_down) begin
					dir_down_q <= 1'b1;
					if (at_bot) begin
						count_q  <= reload;
						update_q <= 1'b1;
					end else begin
						count_q <= count_q - 16'h0001;
					end
				end else begin
					dir_down_q <= 1'b0;
					if (at_top) begin
						count_q  <= `CNT_RESET;
						update_q <= 1'b1;
					end else begin
						count_q <= count_q + 16'h0001;
					end
				end
			end
		end
	end

	// Update is the trigger that peer timers chain on.
	assign trig_out = update_q;

	always @(posedge clk) begin
		if (rst) begin
			hall_change_q <= 1'b0;
		end else begin
			hall_change_q <= hall_chg;
		end
	end

	// The request holds until acknowledged or dma_en drops; a new event wins over the ack.
	always @(posedge clk) begin
		if (rst) begin
			dma_req_q <= 1'b0;
		end else if (dma_en && (update_q || (|ch_event))) begin
			dma_req_q <= 1'b1;
		end else if (dma_ack || !dma_en) begin
			dma_req_q <= 1'b0;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			timer_channel #(.WIDTH(WIDTH)) u_ch (
				.clk        (clk),
				.rst        (rst),
				.mode       (ch_mode[2*i+1:2*i]),
				.compare    (ch_compare[WIDTH*i+WIDTH-1:WIDTH*i]),
				.count      (count_q),
				.tick       (tick),
				.update     (update_q),
				.cap_edge   (cap_edge[i] | (hall_chg & (i == 0))),
				.captured_q (ch_captured[WIDTH*i+WIDTH-1:WIDTH*i]),
				.out_q      (ch_out[i]),
				.event_q    (ch_event[i])
			);
		end
	endgenerate
endmodule // gp_timer

// ===== test/gp_timer_properties.sv
`timescale 1ns/1ps
module gp_timer_properties (
	input wire		clk,
	input wire		rst,
	input wire		enable,
	input wire [1:0]	dir_mode,
	input wire [1:0]	clk_mode,
	input wire		down,
	input wire [15:0]	prescale,
	input wire [15:0]	reload,
	input wire		dbg_freeze_en,
	input wire		dbg_halt,
	input wire		dma_ack,
	input wire [15:0]	count_q,
	input wire		update_q,
	input wire		trig_out,
	input wire		dma_req_q,
	input wire		hall_change_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Only a plain up count with no stall has a fixed next value.
	wire run = enable && !dir_mode && !clk_mode && !down && !prescale
		&& !(dbg_freeze_en && dbg_halt);
	chk_reset_zero: assert property ($fell(rst) |-> !count_q)
		else $error("count not cleared by reset");
	chk_off_hold: assert property (!enable |=> $stable(count_q))
		else $error("count moved while disabled");
	chk_count_range: assert property (count_q <= reload)
		else $error("count above reload");
	chk_up_step: assert property (run && $past(run) && count_q < reload
		|=> count_q == $past(count_q) + 16'h0001) else $error("bad step");
	chk_up_wrap: assert property (run && $past(run) && count_q == reload
		|=> !count_q && update_q) else $error("bad wrap or update");
	chk_trig_follow: assert property (trig_out == update_q)
		else $error("trigger out differs from update");
	chk_halt_hold: assert property (dbg_freeze_en && dbg_halt
		|=> $stable(count_q)) else $error("count moved while halted");
	chk_dma_hold: assert property (dma_req_q && !dma_ack |=> dma_req_q)
		else $error("request dropped without ack");
	chk_hall_pulse: assert property (hall_change_q |=> !hall_change_q)
		else $error("hall pulse too long");
	cover property (update_q);
	cover property (dma_req_q && dma_ack);
	cover property (hall_change_q);
endmodule // gp_timer_properties

// ===== test/peer_model.sv
`timescale 1ns/1ps
module peer_model (
	input wire		clk,
	input wire		trig_run,
	input wire		dma_req_q,
	output reg		trig_in,
	output reg		enc_a,
	output reg		enc_b,
	output reg [2:0]	hall_in,
	output reg [3:0]	ch_in,
	output reg		dma_ack
);
	reg [7:0]	t;
	initial {t, trig_in, enc_a, enc_b, hall_in, ch_in, dma_ack} = 19'h00000;
	// Pins move slowly so every level outlasts the input synchronizers.
	always @(negedge clk) begin
		t <= t + 8'h01;
		dma_ack <= dma_req_q && !dma_ack && t[1];
		trig_in <= trig_run && t[3];
		if (t[2:0] == 3'h0) {enc_a, enc_b} <= {enc_b, ~enc_a};
		if (t[3:0] == 4'h0) hall_in <= {hall_in[1:0], ~hall_in[2]};
		if (t[3:0] == 4'h8) ch_in <= ch_in ^ t[7:4];
	end
endmodule // peer_model

// ===== test/gp_timer_tb.sv
`timescale 1ns/1ps
module gp_timer_tb;
	reg		clk = 1'b0, rst = 1'b1, enable = 1'b0, down = 1'b0;
	reg		dbg_halt = 1'b0, trig_run = 1'b0, armed = 1'b0;
	reg [1:0]	dir_mode = 2'h0, clk_mode = 2'h0;
	reg [15:0]	prescale = 16'h0000;
	reg [7:0]	ch_mode = 8'hE4, s = 8'h29;
	reg [63:0]	ch_compare = 64'h0;
	wire		trig_in, enc_a, enc_b, dma_ack, update_q, dma_req_q;
	wire [2:0]	hall_in;
	wire [3:0]	ch_in;
	integer		n_fail = 0, n_checks = 0, gap = 0, i, k;
	reg [31:0]	q [$];
	gp_timer u_gp_timer (.clk(clk), .rst(rst), .enable(enable),
		.dir_mode(dir_mode), .clk_mode(clk_mode), .down(down),
		.prescale(prescale), .reload(16'h0005), .dbg_freeze_en(1'b1),
		.dbg_halt(dbg_halt), .trig_reset_en(1'b0), .trig_in(trig_in),
		.ch_mode(ch_mode), .ch_compare(ch_compare), .ch_in(ch_in),
		.enc_a(enc_a), .enc_b(enc_b), .hall_in(hall_in), .dma_en(1'b1),
		.dma_ack(dma_ack), .count_q(), .dir_down_q(), .update_q(update_q),
		.trig_out(), .ch_captured(), .ch_out(), .ch_event(),
		.hall_change_q(), .dma_req_q(dma_req_q));
	peer_model u_peer_model (.clk(clk), .trig_run(trig_run),
		.dma_req_q(dma_req_q), .trig_in(trig_in), .enc_a(enc_a),
		.enc_b(enc_b), .hall_in(hall_in), .ch_in(ch_in), .dma_ack(dma_ack));
	always #5 clk = ~clk;
	function [7:0] lfsr(input [7:0] v);
		lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task check(input [31:0] got, input [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("wrong value at %0t: got %0d want %0d", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// The first update after a change only arms; the next gap is clean.
	task run(input [1:0] d, c, input dn, input [15:0] p, input [31:0] w);
		@(negedge clk);
		{dir_mode, clk_mode, down, prescale} = {d, c, dn, p};
		trig_run = (c == 2'h2);
		ch_mode = {ch_mode[5:0], ch_mode[7:6]};
		ch_compare = {4{8'h00, s}};
		armed = 1'b0;
		q.push_back(w);
		for (k = 0; k < 600 && q.size() > 0; k = k + 1) @(negedge clk);
		check(q.size(), 0);
	endtask
	always @(posedge clk) begin
		gap = gap + 1;
		if (update_q === 1'b1) begin
			if (armed && q.size() > 0) check(gap, q.pop_front());
			armed = 1'b1;
			gap = 0;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		enable = 1'b1;
		for (i = 0; i < 3; i = i + 1) begin
			s = lfsr(s);
			run(i[1:0], 2'h0, 1'b0, s[1:0], (i == 2 ? 5 : 6) * (s[1:0] + 1));
		end
		run(2'h0, 2'h0, 1'b1, 16'h0000, 6);
		run(2'h0, 2'h2, 1'b0, 16'h0000, 96);
		clk_mode = 2'h1;
		repeat (200) @(negedge clk);
		run(2'h0, 2'h0, 1'b0, 16'h0003, 24);
		dbg_halt = 1'b1;
		repeat (20) @(negedge clk);
		dbg_halt = 1'b0;
		enable = 1'b0;
		repeat (20) @(negedge clk);
		wrap_up;
	end
	initial begin
		#100000;
		n_fail = n_fail + 1;
		wrap_up;
	end
endmodule // gp_timer_tb
bind gp_timer gp_timer_properties u_gp_timer_properties (.*);
